// file: logic/cpe_pkg.sv
/*
 Shared constants and types for the configuration protection and
 programming entry block. Assumes one 20 MHz device clock and a
 serial programmer that owns the programming clock line.
*/
// Overview of operation
// - Read protect refuses external EEPROM reads, writes.
// - Bit 7 clear blocks external EEPROM writes.
// - CPU EEPROM access is never restricted.
// - Bit 5 read-only to CPU; clear locks config.
// - Eight ID bytes reachable by CPU and programmer.
// - ID bytes readable despite code protection.
// - Programmer drives clock line; one data line.
// - Debug bit at zero enables debugger.
// - Debugger reserves pins, stack and memory.
// - Low-voltage enable dedicates the entry pin.
// - High-voltage master clear entry always works.
// - Low-voltage enable changes only in HV mode.
// - Enable cleared: HV entry only, pin GPIO.
// - Low-voltage enable reads one when shipped.
// - Low-voltage enable disables entry pin pull-up.
package cpe_pkg;

	// ---------------------------------------------------------------
	// Address map
	// ---------------------------------------------------------------
	localparam logic [23:0] PROT_ADDR = 24'h30000B;
	localparam logic [23:0] DBG_ADDR  = 24'h300006;
	localparam logic [23:0] RDP_ADDR  = 24'h300009;
	localparam logic [23:0] BOOT_LO   = 24'h000000;
	localparam logic [23:0] BOOT_HI   = 24'h0001FF;
	localparam logic [23:0] FL_HI     = 24'h1FFFFF;
	localparam logic [23:0] ID_LO     = 24'h200000;
	localparam logic [23:0] ID_HI     = 24'h200007;
	localparam logic [23:0] EE_LO     = 24'hF00000;
	localparam logic [23:0] EE_HI     = 24'hF000FF;

	// ---------------------------------------------------------------
	// Register fields and reset values
	// ---------------------------------------------------------------
	localparam int          EEWP_BIT   = 7;
	localparam int          BOOTWP_BIT = 6;
	localparam int          CFGWP_BIT  = 5;
	localparam logic [7:0]  PROT_RST   = 8'hE0;
	localparam logic [7:0]  PROT_USED  = 8'hE0;
	localparam int          DEBUG_BIT  = 7;
	localparam int          LVP_BIT    = 2;
	localparam logic [7:0]  DBG_RST    = 8'h84;
	localparam logic [7:0]  DBG_USED   = 8'h84;
	localparam int          EERP_BIT   = 7;
	localparam logic [7:0]  RDP_RST    = 8'h80;
	localparam logic [7:0]  RDP_USED   = 8'h80;
	localparam logic [7:0]  ID_RST     = 8'hFF;

	// ---------------------------------------------------------------
	// Serial frame and debugger resources
	// ---------------------------------------------------------------
	localparam int          CMD_W      = 4;
	localparam int          DATA_W     = 8;
	localparam int          FRAME_BITS = 36;
	localparam int          RD_FIRST   = 28;
	localparam logic [3:0]  CMD_NOP    = 4'h0;
	localparam logic [3:0]  CMD_READ   = 4'h1;
	localparam logic [3:0]  CMD_WRITE  = 4'h2;
	localparam logic [1:0]  DBG_STACK  = 2'h2;
	localparam logic [9:0]  DBG_PROG   = 10'h200;
	localparam logic [3:0]  DBG_DATA   = 4'hA;

	typedef enum logic [1:0] {ENT_RUN, ENT_HV, ENT_LV} cpe_entry_t;
	typedef enum logic {OP_IDLE, OP_WAIT} cpe_op_t;

	function automatic logic in_rng(
		input logic [23:0] ad,
		input logic [23:0] lo,
		input logic [23:0] hi
	);
		return (ad >= lo) && (ad <= hi);
	endfunction

endpackage

// file: logic/cpe_link_if.sv
/*
 Carrier between the serial link logic and the protection core.
 Assumes a four-phase req/ack level handshake across the domains;
 cmd, addr and wdata hold while req is high, rdata while ack is.
*/
`timescale 1ns/1ps
interface cpe_link_if;
	import cpe_pkg::*;
	logic              req;
	logic [CMD_W-1:0]  cmd;
	logic [23:0]       addr;
	logic [DATA_W-1:0] wdata;
	logic              ack;
	logic [DATA_W-1:0] rdata;
	modport link (output req, cmd, addr, wdata, input ack, rdata);
	modport core (input req, cmd, addr, wdata, output ack, rdata);
endinterface

// file: logic/cpe_serial_link.sv
/*
 Serial shifter on the programmer's clock. Takes 36-bit frames
 MSB first (command, address, data) and hands them to the core.
 Assumes the clock may stop between frames.
*/
`timescale 1ns/1ps
module cpe_serial_link
	import cpe_pkg::*;
(
	input  wire logic prog_clock,
	input  wire logic link_idle,
	input  wire logic data_i,
	output logic      data_o,
	output logic      data_oe_n,
	cpe_link_if.link  lnk
);
	logic [1:0]            rst_s_q;
	logic                  lrst;
	logic [5:0]            cnt_q;
	logic [5:0]            cnt_d;
	logic [FRAME_BITS-1:0] sh_q;
	logic [FRAME_BITS-1:0] word;
	logic [CMD_W-1:0]      fcmd_q;
	logic [DATA_W-1:0]     rd_q;
	logic [2:0]            ack_s_q;
	logic [2:0]            bix;

	// Idle raises the link reset at once, as the programmer's clock may
	// be stopped then; release follows two of its rising edges.
	always_ff @(posedge prog_clock or posedge link_idle) begin
		if (link_idle) begin
			rst_s_q <= 2'h3;
		end else begin
			rst_s_q <= {rst_s_q[0], 1'b0};
		end
	end
	assign lrst = rst_s_q[1];
	assign word = {sh_q[FRAME_BITS-2:0], data_i};
	assign cnt_d = (cnt_q == 6'(FRAME_BITS - 1)) ? 6'h00 : cnt_q + 6'h01;
	assign bix = 3'(cnt_d - 6'(RD_FIRST));

	always_ff @(posedge prog_clock) begin
		if (lrst) begin
			sh_q <= '0;
			cnt_q <= 6'h00;
			fcmd_q <= CMD_NOP;
		end else begin
			sh_q <= word;
			cnt_q <= cnt_d;
			if (cnt_q == 6'(CMD_W - 1)) begin
				fcmd_q <= word[CMD_W-1:0];
			end
		end
	end

	// Words hold while req is high, so the core reads them safely.
	always_ff @(posedge prog_clock) begin
		if (lrst) begin
			lnk.req <= 1'b0;
			lnk.cmd <= CMD_NOP;
			lnk.addr <= '0;
			lnk.wdata <= '0;
		end else if (cnt_q == 6'(FRAME_BITS - 1) && !lnk.req
			&& word[FRAME_BITS-1 -: CMD_W] != CMD_NOP) begin
			lnk.req <= 1'b1;
			lnk.cmd <= word[FRAME_BITS-1 -: CMD_W];
			lnk.addr <= word[DATA_W +: 24];
			lnk.wdata <= word[DATA_W-1:0];
		end else if (ack_s_q[1]) begin
			lnk.req <= 1'b0;
		end
	end

	always_ff @(posedge prog_clock) begin
		if (lrst) begin
			ack_s_q <= 3'h0;
			rd_q <= '0;
		end else begin
			ack_s_q <= {ack_s_q[1:0], lnk.ack};
			if (ack_s_q[2:1] == 2'b01) begin
				rd_q <= lnk.rdata;
			end
		end
	end

	// The device drives data only in the data phase of a read frame.
	// The pin is released at once when programming ends, clock or not.
	always_ff @(posedge prog_clock or posedge link_idle) begin
		if (link_idle) begin
			data_oe_n <= 1'b1;
			data_o <= 1'b0;
		end else if (lrst) begin
			data_oe_n <= 1'b1;
			data_o <= 1'b0;
		end else if (fcmd_q == CMD_READ && cnt_d >= 6'(RD_FIRST)) begin
			data_oe_n <= 1'b0;
			data_o <= rd_q[3'(DATA_W - 1) - bix];
		end else begin
			data_oe_n <= 1'b1;
			data_o <= 1'b0;
		end
	end

	chk_read_drive: assert property (
		@(posedge prog_clock) disable iff (lrst)
		!data_oe_n |-> fcmd_q == CMD_READ && cnt_q >= 6'(RD_FIRST))
		else $error("data driven outside read phase");

	chk_req_frame: assert property (
		@(posedge prog_clock) disable iff (lrst)
		$rose(lnk.req) |-> $past(cnt_q) == 6'(FRAME_BITS - 1))
		else $error("request raised mid frame");

endmodule

// file: logic/cpe_protect_core.sv
/*
 Protection and programming entry core. Gates programmer access to
 data EEPROM, boot block, ID bytes and configuration bytes, and
 decides programming entry. Assumes memories answer reads within the
 cycle of the request and that srst is not raised during programming.
*/
`timescale 1ns/1ps
module cpe_protect_core
	import cpe_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        prog_clock_pin,
	input  wire logic        prog_data_pin_i,
	output logic             prog_data_pin_o,
	output logic             prog_data_pin_oe_n,
	input  wire logic        prog_entry_pin,
	input  wire logic        master_clear_hv_pin,
	input  wire logic        entry_pullup_req,
	input  wire logic        cpu_ee_req,
	input  wire logic        cpu_ee_we,
	input  wire logic [7:0]  cpu_ee_addr,
	input  wire logic [7:0]  cpu_ee_wdata,
	input  wire logic        cpu_tbl_req,
	input  wire logic        cpu_tbl_we,
	input  wire logic [23:0] cpu_tbl_addr,
	input  wire logic [7:0]  cpu_tbl_wdata,
	output logic [7:0]       cpu_tbl_rdata,
	output logic             ee_req,
	output logic             ee_we,
	output logic [7:0]       ee_addr,
	output logic [7:0]       ee_wdata,
	input  wire logic [7:0]  ee_rdata,
	output logic             fl_req,
	output logic             fl_we,
	output logic [23:0]      fl_addr,
	output logic [7:0]       fl_wdata,
	input  wire logic [7:0]  fl_rdata,
	output logic             prog_mode,
	output logic             hv_entry,
	output logic             debug_enable,
	output logic             dbg_pins_reserved,
	output logic [1:0]       dbg_stack_levels,
	output logic [9:0]       dbg_prog_bytes,
	output logic [3:0]       dbg_data_bytes,
	output logic             entry_pin_gpio_en,
	output logic             entry_pin_pullup_en,
	output logic [7:0]       config_protect_high
);
	cpe_link_if lnk ();

	logic [1:0]  hv_s_q;
	logic [1:0]  pin_s_q;
	logic [1:0]  req_s_q;
	cpe_entry_t  ent_q;
	cpe_op_t     op_q;
	logic [7:0]  prot_q;
	logic [7:0]  dbg_q;
	logic [7:0]  rdp_q;
	logic [7:0]  id_q [8];
	logic        ack_q;
	logic        sel_ee_q;
	logic        idle_q;
	logic [7:0]  rdata_q;
	logic [23:0] a;
	logic        low_volt_prog_enable;
	logic        go;
	logic        is_rd;
	logic        is_wr;
	logic        in_ee;
	logic        in_fl;
	logic        in_boot;
	logic        in_id;
	logic        ee_go;
	logic        fl_go;
	logic [7:0]  lvp_m;
	logic [7:0]  id_cpu;
	logic [7:0]  id_ext;

	function automatic logic [7:0] reg_rd(input logic [23:0] ad);
		if (in_rng(ad, ID_LO, ID_HI)) begin
			return id_q[ad[2:0]];
		end else if (ad == PROT_ADDR) begin
			return prot_q;
		end else if (ad == DBG_ADDR) begin
			return dbg_q;
		end else if (ad == RDP_ADDR) begin
			return rdp_q;
		end
		return 8'h00;
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers and programming entry
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			hv_s_q <= 2'h0;
			pin_s_q <= 2'h0;
			req_s_q <= 2'h0;
		end else begin
			hv_s_q <= {hv_s_q[0], master_clear_hv_pin};
			pin_s_q <= {pin_s_q[0], prog_entry_pin};
			req_s_q <= {req_s_q[0], lnk.req};
		end
	end

	assign low_volt_prog_enable = dbg_q[LVP_BIT];
	assign lvp_m = 8'h01 << LVP_BIT;

	always_ff @(posedge clock) begin
		if (srst) begin
			ent_q <= ENT_RUN;
		end else begin
			case (ent_q)
			ENT_RUN: begin
				if (hv_s_q[1]) begin
					ent_q <= ENT_HV;
				end else if (pin_s_q[1] && low_volt_prog_enable) begin
					ent_q <= ENT_LV;
				end
			end
			ENT_HV: begin
				if (!hv_s_q[1]) begin
					ent_q <= ENT_RUN;
				end
			end
			ENT_LV: begin
				if (!pin_s_q[1]) begin
					ent_q <= ENT_RUN;
				end
			end
			default: begin
				ent_q <= ENT_RUN;
			end
			endcase
		end
	end

	// Holds the link logic in reset whenever programming is not active.
	always_ff @(posedge clock) begin
		if (srst) begin
			idle_q <= 1'b1;
		end else begin
			idle_q <= ent_q == ENT_RUN;
		end
	end

	assign prog_mode = ent_q != ENT_RUN;
	assign hv_entry = ent_q == ENT_HV;
	assign entry_pin_gpio_en = !low_volt_prog_enable;
	assign entry_pin_pullup_en = entry_pullup_req && !low_volt_prog_enable;
	assign config_protect_high = prot_q;

	cpe_serial_link u_link (
		.prog_clock (prog_clock_pin),
		.link_idle  (idle_q),
		.data_i     (prog_data_pin_i),
		.data_o     (prog_data_pin_o),
		.data_oe_n  (prog_data_pin_oe_n),
		.lnk        (lnk.link)
	);

	// ---------------------------------------------------------------
	// Programmer access decode
	// ---------------------------------------------------------------
	assign a = lnk.addr;
	assign is_rd = lnk.cmd == CMD_READ;
	assign is_wr = lnk.cmd == CMD_WRITE;
	assign in_ee = in_rng(a, EE_LO, EE_HI);
	assign in_fl = in_rng(a, BOOT_LO, FL_HI);
	assign in_boot = in_rng(a, BOOT_LO, BOOT_HI);
	assign in_id = in_rng(a, ID_LO, ID_HI);
	assign go = req_s_q[1] && !ack_q && op_q == OP_IDLE && prog_mode
		&& !cpu_ee_req && !cpu_tbl_req;
	assign ee_go = go && in_ee && rdp_q[EERP_BIT]
		&& (is_rd || (is_wr && prot_q[EEWP_BIT]));
	assign fl_go = go && in_fl
		&& (is_rd || (is_wr && (!in_boot || prot_q[BOOTWP_BIT])));
	assign id_cpu = id_q[cpu_tbl_addr[2:0]];
	assign id_ext = id_q[a[2:0]];
	assign lnk.ack = ack_q;
	assign lnk.rdata = rdata_q;

	// The CPU always wins the EEPROM port; the programmer waits.
	always_ff @(posedge clock) begin
		if (srst) begin
			ee_req <= 1'b0;
			ee_we <= 1'b0;
			ee_addr <= 8'h00;
			ee_wdata <= 8'h00;
		end else if (cpu_ee_req) begin
			ee_req <= 1'b1;
			ee_we <= cpu_ee_we;
			ee_addr <= cpu_ee_addr;
			ee_wdata <= cpu_ee_wdata;
		end else if (ee_go) begin
			ee_req <= 1'b1;
			ee_we <= is_wr;
			ee_addr <= a[7:0];
			ee_wdata <= lnk.wdata;
		end else begin
			ee_req <= 1'b0;
			ee_we <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			fl_req <= 1'b0;
			fl_we <= 1'b0;
			fl_addr <= 24'h000000;
			fl_wdata <= 8'h00;
		end else if (fl_go) begin
			fl_req <= 1'b1;
			fl_we <= is_wr;
			fl_addr <= a;
			fl_wdata <= lnk.wdata;
		end else begin
			fl_req <= 1'b0;
			fl_we <= 1'b0;
		end
	end

	// Refused or unmapped reads answer zero; refused writes are dropped.
	always_ff @(posedge clock) begin
		if (srst) begin
			op_q <= OP_IDLE;
			ack_q <= 1'b0;
			sel_ee_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			case (op_q)
			OP_IDLE: begin
				if ((ee_go || fl_go) && is_rd) begin
					op_q <= OP_WAIT;
					sel_ee_q <= ee_go;
				end else if (go) begin
					rdata_q <= reg_rd(a);
					ack_q <= 1'b1;
				end else if (!req_s_q[1]) begin
					ack_q <= 1'b0;
				end
			end
			OP_WAIT: begin
				rdata_q <= sel_ee_q ? ee_rdata : fl_rdata;
				ack_q <= 1'b1;
				op_q <= OP_IDLE;
			end
			default: begin
				op_q <= OP_IDLE;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Configuration bytes and ID locations
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			prot_q <= PROT_RST;
			dbg_q <= DBG_RST;
			rdp_q <= RDP_RST;
		end else if (go && is_wr && prot_q[CFGWP_BIT]) begin
			if (a == PROT_ADDR) begin
				prot_q <= prot_q & lnk.wdata;
			end else if (a == DBG_ADDR) begin
				dbg_q <= (lnk.wdata & DBG_USED & ~lvp_m)
					| ((hv_entry ? lnk.wdata : dbg_q) & lvp_m);
			end else if (a == RDP_ADDR) begin
				rdp_q <= lnk.wdata & RDP_USED;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < 8; i++) begin
				id_q[i] <= ID_RST;
			end
		end else if (cpu_tbl_req && cpu_tbl_we
			&& in_rng(cpu_tbl_addr, ID_LO, ID_HI)) begin
			id_q[cpu_tbl_addr[2:0]] <= cpu_tbl_wdata;
		end else if (go && is_wr && in_id) begin
			id_q[a[2:0]] <= lnk.wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cpu_tbl_rdata <= 8'h00;
		end else if (cpu_tbl_req && !cpu_tbl_we) begin
			cpu_tbl_rdata <= reg_rd(cpu_tbl_addr);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			debug_enable <= 1'b0;
			dbg_pins_reserved <= 1'b0;
			dbg_stack_levels <= 2'h0;
			dbg_prog_bytes <= 10'h000;
			dbg_data_bytes <= 4'h0;
		end else begin
			debug_enable <= !dbg_q[DEBUG_BIT];
			dbg_pins_reserved <= !dbg_q[DEBUG_BIT];
			dbg_stack_levels <= dbg_q[DEBUG_BIT] ? 2'h0 : DBG_STACK;
			dbg_prog_bytes <= dbg_q[DEBUG_BIT] ? 10'h000 : DBG_PROG;
			dbg_data_bytes <= dbg_q[DEBUG_BIT] ? 4'h0 : DBG_DATA;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	chk_ee_read_block: assert property (
		go && in_ee && !rdp_q[EERP_BIT] |=> !ee_req)
		else $error("ee access despite read protect");

	chk_ee_write_block: assert property (
		go && in_ee && is_wr && !prot_q[EEWP_BIT] |=> !ee_req)
		else $error("ee write despite write protect");

	chk_cpu_ee_pass: assert property (
		cpu_ee_req |=> ee_req && ee_we == $past(cpu_ee_we)
			&& ee_addr == $past(cpu_ee_addr))
		else $error("cpu ee access not passed");

	chk_cfg_user_ro: assert property (
		!prog_mode |=> $stable(prot_q) && $stable(dbg_q))
		else $error("config changed in user mode");

	chk_cfg_lock: assert property (
		!prot_q[CFGWP_BIT] |=> $stable(prot_q) && $stable(rdp_q))
		else $error("config changed while locked");

	chk_id_cpu_read: assert property (
		cpu_tbl_req && !cpu_tbl_we && in_rng(cpu_tbl_addr, ID_LO, ID_HI)
		|=> cpu_tbl_rdata == $past(id_cpu))
		else $error("cpu id read wrong");

	chk_id_prot_read: assert property (
		go && is_rd && in_id |=> ack_q && rdata_q == $past(id_ext))
		else $error("programmer id read wrong");

	chk_debug_on: assert property (
		$fell(dbg_q[DEBUG_BIT]) |=> debug_enable ##1 debug_enable)
		else $error("debugger not enabled");

	chk_debug_res: assert property (
		debug_enable |-> dbg_pins_reserved && dbg_stack_levels == DBG_STACK
			&& dbg_prog_bytes == DBG_PROG && dbg_data_bytes == DBG_DATA)
		else $error("debug resources not reserved");

	chk_entry_pin: assert property (
		low_volt_prog_enable |-> !entry_pin_gpio_en && !entry_pin_pullup_en)
		else $error("entry pin not dedicated");

	chk_lv_refused: assert property (
		ent_q == ENT_RUN && !hv_s_q[1] && !low_volt_prog_enable |=> ent_q == ENT_RUN)
		else $error("low voltage entry while disabled");

	chk_hv_entry: assert property (
		ent_q == ENT_RUN && hv_s_q[1] |=> ent_q == ENT_HV)
		else $error("high voltage entry missed");

	chk_lvp_hv_only: assert property (
		ent_q != ENT_HV |=> $stable(low_volt_prog_enable))
		else $error("lvp changed outside hv mode");

	chk_boot_wp: assert property (
		go && in_boot && is_wr && !prot_q[BOOTWP_BIT] |=> !fl_req)
		else $error("boot write despite protect");

	chk_prot_unused: assert property (
		(prot_q & ~PROT_USED) == 8'h00 ##1 (prot_q & ~PROT_USED) == 8'h00)
		else $error("unused protect bits set");

endmodule

// file: test/cpe_prog_model.sv
/*
 Serial programmer model: owns the programming clock and one data line.
 Assumes the bench resolves the shared data wire from both drivers.
*/
`timescale 1ns/1ps
module cpe_prog_model
(
	output logic       prog_clock,
	output logic       line_d,
	output logic       line_en,
	input  wire logic  line_in,
	output logic [7:0] rd_byte,
	output logic       rd_stb
);
	initial begin
		prog_clock = 1'b0;
		line_d = 1'b0;
		line_en = 1'b1;
		rd_byte = 8'h00;
		rd_stb = 1'b0;
	end

	// The clock only runs inside these tasks and stands still otherwise.
	task automatic pulses(input int n);
		repeat (n) begin
			#24 prog_clock = 1'b1;
			#24 prog_clock = 1'b0;
		end
	endtask

	task automatic frame(input logic [3:0] c, input logic [23:0] a,
		input logic [7:0] d, input logic k);
		logic [35:0] f;
		logic [7:0]  r;
		f = {c, a, d};
		r = 8'h00;
		for (int i = 0; i < 36; i++) begin
			// Each read bit is launched on the rising edge before it, so
			// it is taken just ahead of the next rising edge.
			if (c == 4'h1 && i >= 28) begin
				line_en = 1'b0;
				r = {r[6:0], line_in};
			end else begin
				line_en = 1'b1;
				line_d = f[35-i];
			end
			pulses(1);
		end
		line_en = 1'b1;
		line_d = 1'b0;
		if (k) begin
			rd_byte = r;
			rd_stb = 1'b1;
			#1 rd_stb = 1'b0;
		end
	endtask
endmodule

// file: test/tb.sv
/*
 Self-checking bench for the protection core with a programmer model.
 Assumes memories answer within the cycle of each request.
*/
`timescale 1ns/1ps
module tb
	import cpe_pkg::*;
;
	logic        clock = 1'b0, srst = 1'b1, flip = 1'b0;
	logic        prog_entry_pin = 1'b0, master_clear_hv_pin = 1'b0;
	logic        entry_pullup_req = 1'b1, have = 1'b0;
	logic        cpu_ee_req = 1'b0, cpu_ee_we = 1'b0;
	logic        cpu_tbl_req = 1'b0, cpu_tbl_we = 1'b0;
	logic [7:0]  cpu_ee_addr = 8'h00, cpu_ee_wdata = 8'h00, prev;
	logic [7:0]  cpu_tbl_wdata = 8'h00, ee_rdata, fl_rdata;
	logic [23:0] cpu_tbl_addr = 24'h000000;
	logic [31:0] seed = 32'h42CA;
	wire         prog_clock_pin, prog_data_pin_i, m_d, m_en, m_stb;
	wire  [7:0]  m_byte;
	logic        prog_data_pin_o, prog_data_pin_oe_n, ee_req, ee_we, fl_req;
	logic        fl_we, prog_mode, hv_entry, debug_enable, dbg_pins_reserved;
	logic        entry_pin_gpio_en, entry_pin_pullup_en;
	logic [1:0]  dbg_stack_levels;
	logic [9:0]  dbg_prog_bytes;
	logic [3:0]  dbg_data_bytes;
	logic [7:0]  cpu_tbl_rdata, ee_addr, ee_wdata, fl_wdata;
	logic [7:0]  config_protect_high;
	logic [23:0] fl_addr;
	logic [33:0] got, mq[$];
	logic [7:0]  rq[$];
	int          miscompares = 0, samples_checked = 0;

	cpe_protect_core uut (.clock, .srst, .prog_clock_pin, .prog_data_pin_i,
		.prog_data_pin_o, .prog_data_pin_oe_n, .prog_entry_pin,
		.master_clear_hv_pin, .entry_pullup_req, .cpu_ee_req, .cpu_ee_we,
		.cpu_ee_addr, .cpu_ee_wdata, .cpu_tbl_req, .cpu_tbl_we, .cpu_tbl_addr,
		.cpu_tbl_wdata, .cpu_tbl_rdata, .ee_req, .ee_we, .ee_addr, .ee_wdata,
		.ee_rdata, .fl_req, .fl_we, .fl_addr, .fl_wdata, .fl_rdata, .prog_mode,
		.hv_entry, .debug_enable, .dbg_pins_reserved, .dbg_stack_levels,
		.dbg_prog_bytes, .dbg_data_bytes, .entry_pin_gpio_en,
		.entry_pin_pullup_en, .config_protect_high);
	cpe_prog_model m (.prog_clock(prog_clock_pin), .line_d(m_d),
		.line_en(m_en), .line_in(prog_data_pin_i), .rd_byte(m_byte),
		.rd_stb(m_stb));

	// ---------------------------------------------------------------
	// Clock, shared data wire and memories
	// ---------------------------------------------------------------
	always #25 clock = ~clock;
	// A released line drifts instead of keeping its last value.
	always @(posedge prog_clock_pin) flip <= ~flip;
	assign prog_data_pin_i = !prog_data_pin_oe_n ? prog_data_pin_o :
		(m_en ? m_d : flip);
	// The core takes read data in the cycle in which the request stands.
	assign ee_rdata = ee_addr ^ 8'h5A;
	assign fl_rdata = fl_addr[7:0] ^ 8'hA5;
	assign got = ee_req ? {1'b0, ee_we, 16'h0, ee_addr, ee_we ? ee_wdata : 8'h0}
		: {1'b1, fl_we, fl_addr, fl_we ? fl_wdata : 8'h0};

	// ---------------------------------------------------------------
	// Result monitors
	// ---------------------------------------------------------------
	always @(posedge clock) begin
		if (ee_req || fl_req) begin
			if (mq.size() == 0) chk("mem_req_unexpected", 34'h0, 34'h1);
			else chk("mem_req", mq.pop_front(), got);
		end
	end
	always @(posedge m_stb) begin
		if (rq.size() == 0) chk("serial_rd_unexpected", 34'h0, 34'h1);
		else chk("serial_rd", {26'h0, rq.pop_front()}, {26'h0, m_byte});
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [33:0] e,
		input logic [33:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic final_report;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic mexp(input logic fl, input logic we,
		input logic [23:0] a, input logic [7:0] d);
		mq.push_back({fl, we, fl ? a : {16'h0, a[7:0]}, we ? d : 8'h0});
	endtask
	// Each operation is followed by a no-op frame that spaces the next.
	task automatic op(input logic [3:0] c, input logic [23:0] a,
		input logic [7:0] d, input logic k);
		m.frame(c, a, d, k);
		m.frame(CMD_NOP, 24'h0, 8'h0, 1'b0);
	endtask
	// Any handshake reloads the link's read byte, so a pending read
	// result is fetched first by a spare read of the first ID byte.
	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		if (have) rd(ID_LO, 8'hFF);
		have = 1'b0;
		op(CMD_WRITE, a, d, 1'b0);
	endtask
	// A read frame returns the byte of the previous read.
	task automatic rd(input logic [23:0] a, input logic [7:0] e);
		if (have) rq.push_back(prev);
		op(CMD_READ, a, 8'h0, have);
		prev = e;
		have = 1'b1;
	endtask
	task automatic enter(input logic hv);
		if (hv) master_clear_hv_pin = 1'b1;
		else prog_entry_pin = 1'b1;
		tick(5);
		m.pulses(2);
		have = 1'b0;
	endtask
	task automatic leave;
		master_clear_hv_pin = 1'b0;
		prog_entry_pin = 1'b0;
		tick(5);
	endtask
	task automatic cpu_ee(input logic we);
		seed = lfsr(seed);
		cpu_ee_req = 1'b1;
		cpu_ee_we = we;
		cpu_ee_addr = seed[7:0];
		cpu_ee_wdata = seed[15:8];
		mexp(1'b0, we, {16'h0, seed[7:0]}, seed[15:8]);
		tick(1);
		cpu_ee_req = 1'b0;
		tick(2);
	endtask

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		#300000;
		miscompares++;
		final_report;
	end
	initial begin
		repeat (6) @(posedge clock);
		#2 srst = 1'b0;
		tick(1);
		chk("cfg_prot", 34'hE0, config_protect_high);
		chk("gpio_en", 34'h0, entry_pin_gpio_en);
		chk("pullup_en", 34'h0, entry_pin_pullup_en);
		chk("dbg_res", 34'h0, {debug_enable, dbg_pins_reserved,
			dbg_stack_levels, dbg_prog_bytes, dbg_data_bytes});
		enter(1'b0);
		chk("lv_mode", 34'h2, {prog_mode, hv_entry});
		wr(DBG_ADDR, 8'h80);
		chk("lvp_kept", 34'h0, entry_pin_gpio_en);
		leave;
		chk("run_mode", 34'h0, prog_mode);
		enter(1'b1);
		chk("hv_mode", 34'h3, {prog_mode, hv_entry});
		rd(PROT_ADDR, 8'hE0);
		rd(ID_LO, 8'hFF);
		mexp(1'b0, 1'b0, 24'hF00010, 8'h0);
		rd(24'hF00010, 8'h4A);
		seed = lfsr(seed);
		mexp(1'b1, 1'b1, 24'h000010, seed[7:0]);
		wr(24'h000010, seed[7:0]);
		mexp(1'b0, 1'b1, 24'hF00020, 8'h44);
		wr(24'hF00020, 8'h44);
		wr(DBG_ADDR, 8'h00);
		chk("dbg_on", {16'h0, 1'b1, 1'b1, 2'h2, 10'h200, 4'hA},
			{debug_enable, dbg_pins_reserved, dbg_stack_levels,
			dbg_prog_bytes, dbg_data_bytes});
		chk("gpio_pu", 34'h3, {entry_pin_gpio_en, entry_pin_pullup_en});
		wr(PROT_ADDR, 8'h3F);
		chk("cfg_prot", 34'h20, config_protect_high);
		wr(24'hF00020, 8'h55);
		wr(24'h000010, 8'h66);
		mexp(1'b0, 1'b0, 24'hF00030, 8'h0);
		rd(24'hF00030, 8'h6A);
		cpu_ee(1'b1);
		wr(RDP_ADDR, 8'h00);
		rd(24'hF00030, 8'h00);
		rd(24'h200002, 8'hFF);
		cpu_ee(1'b0);
		seed = lfsr(seed);
		cpu_tbl_req = 1'b1;
		cpu_tbl_we = 1'b1;
		cpu_tbl_addr = 24'h200003;
		cpu_tbl_wdata = seed[7:0];
		tick(1);
		cpu_tbl_we = 1'b0;
		tick(1);
		cpu_tbl_req = 1'b0;
		chk("tbl_rd", {26'h0, seed[7:0]}, cpu_tbl_rdata);
		tick(1);
		cpu_tbl_req = 1'b1;
		cpu_tbl_we = 1'b1;
		cpu_tbl_addr = PROT_ADDR;
		cpu_tbl_wdata = 8'h00;
		tick(1);
		cpu_tbl_req = 1'b0;
		tick(2);
		chk("cfg_cpu", 34'h20, config_protect_high);
		rd(24'h200003, seed[7:0]);
		rd(PROT_ADDR, 8'h20);
		wr(PROT_ADDR, 8'h00);
		chk("cfg_prot", 34'h0, config_protect_high);
		wr(DBG_ADDR, 8'h84);
		chk("cfg_locked", 34'h1, debug_enable);
		leave;
		enter(1'b0);
		chk("lv_refused", 34'h0, prog_mode);
		leave;
		chk("queues", 34'h0, mq.size() + rq.size());
		final_report;
	end
endmodule
